// [core/pg_delay_timer.sv]
// One power-good delay channel: waits a programmed number of 5 ms ticks
// after its rail group is in regulation, then asserts its output.
// Assumes a 5 ms tick pulse from a private per-channel prescaler in the parent.
`timescale 1ns/10ps
`include "rail_ctrl_regs.svh"

module pg_delay_timer
#(
   parameter int TICK_W = 5
)
(
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              tick,
   input  wire logic              rails_ok,
   input  wire logic [TICK_W-1:0] ticks_req,
   output logic                   pg_out
);

   logic [TICK_W-1:0] cnt_r;
   logic              pg_r;
   wire               done = (cnt_r >= ticks_req);

   // --------------------------------------------------------------
   // Delay counter
   // --------------------------------------------------------------
   // Counter clears whenever the group drops out of regulation.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !rails_ok)
         cnt_r <= '0;
      else if (tick && !done)
         cnt_r <= cnt_r + TICK_W'(1);
   end

   // Output asserts only once the full delay has elapsed.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         pg_r <= 1'b0;
      else
         pg_r <= rails_ok && done;
   end

   assign pg_out = pg_r;

   a_drop_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !rails_ok |=> !pg_r && cnt_r == '0)
      else $error("power good held after rail dropout");

   a_pg_needs_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pg_r |-> $past(rails_ok) && $past(done))
      else $error("power good asserted before delay elapsed");

endmodule : pg_delay_timer

// [core/rail_ctrl_bank.sv]
// Rail control and power-good delay register bank: aux linear rail
// voltage codes, controller modes and software enables, and three
// power-good delay channels.
// Assumes a simple synchronous 8-bit register port from the serial
// management block, and rail status inputs synchronous to sys_clk.
`timescale 1ns/10ps
`include "rail_ctrl_regs.svh"

module rail_ctrl_bank
   import rail_ctrl_pkg::*;
#(
   parameter int TICK_CYC = `CYC_PER_MS * `MS_PER_TICK
)
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   input  wire logic       sleep_active,
   input  wire logic [2:0] ctrl_pin_en,
   input  wire logic [2:0] group_ok,
   input  wire logic [2:0] host_ctrl,
   input  wire logic [2:0] host_level,
   input  wire logic       out_two_vtt_use,
   output logic      [3:0] aux_rail_target_code,
   output ctrl_fields_t    ctrl_out,
   output logic            general_output_one,
   output logic            general_output_two,
   output logic            general_output_four
);

   // --------------------------------------------------------------
   // Register storage
   // --------------------------------------------------------------
   aux_volt_t    aux_volt_r;
   logic [7:0]   ctrl_r;
   logic [7:0]   pg_delay_r;

   wire wr_aux  = reg_wr && (reg_addr == `OFS_AUX_VOLT);
   wire wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
   wire wr_pgd  = reg_wr && (reg_addr == `OFS_PG_DELAY);

   // Writes land in the addressed register; reserved control bits drop.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         aux_volt_r <= `RST_AUX_VOLT;
         ctrl_r     <= `RST_CTRL;
         pg_delay_r <= `RST_PG_DELAY;
      end
      else
      begin
         if (wr_aux)
            aux_volt_r <= reg_wdata;
         if (wr_ctrl)
            ctrl_r <= reg_wdata & `CTRL_WR_MASK;
         if (wr_pgd)
            pg_delay_r <= reg_wdata;
      end
   end

   // --------------------------------------------------------------
   // Read path
   // --------------------------------------------------------------
   logic [7:0] rd_mux;
   // Unmapped addresses read as zero.
   always_comb
   begin
      case (reg_addr)
         `OFS_AUX_VOLT: rd_mux = aux_volt_r;
         `OFS_CTRL:     rd_mux = ctrl_r;
         `OFS_PG_DELAY: rd_mux = pg_delay_r;
         default:       rd_mux = 8'h00;
      endcase
   end

   // Read data is registered and valid the cycle after the strobe.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rd_mux;
      end
   end

   // --------------------------------------------------------------
   // Rail targets and controller controls
   // --------------------------------------------------------------
   wire [3:0] aux_sel = sleep_active ? aux_volt_r.sleep_code
                                     : aux_volt_r.normal_code;

   ctrl_fields_t ctrl_nxt;
   assign ctrl_nxt.three_mode = ctrl_r[`BIT_CTRL3_MODE];
   assign ctrl_nxt.two_mode   = ctrl_r[`BIT_CTRL2_MODE];
   assign ctrl_nxt.one_mode   = ctrl_r[`BIT_CTRL1_MODE];
   assign ctrl_nxt.three_en   = ctrl_r[`BIT_CTRL3_EN] && ctrl_pin_en[2];
   assign ctrl_nxt.two_en     = ctrl_r[`BIT_CTRL2_EN] && ctrl_pin_en[1];
   assign ctrl_nxt.one_en     = ctrl_r[`BIT_CTRL1_EN] && ctrl_pin_en[0];

   // Rail controls are registered so outputs come from flip-flops.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         aux_rail_target_code <= 4'h0;
         ctrl_out             <= '0;
      end
      else
      begin
         aux_rail_target_code <= aux_sel;
         ctrl_out             <= ctrl_nxt;
      end
   end

   // --------------------------------------------------------------
   // Shared 5 ms time base
   // --------------------------------------------------------------
   // The shared tick drives only the cover point below; each delay channel
   // restarts its own prescaler when its group drops, so no delay step
   // carries the up-to-one-tick phase of the start.
   logic [31:0] tb_cnt_r;
   logic        tick_r;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || tb_cnt_r == 32'(TICK_CYC - 1))
         tb_cnt_r <= 32'h0000_0000;
      else
         tb_cnt_r <= tb_cnt_r + 32'h0000_0001;
   end
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         tick_r <= 1'b0;
      else
         tick_r <= (tb_cnt_r == 32'(TICK_CYC - 1));
   end

   // Per-channel cycle-exact counters give the exact nominal delay.
   // Code to tick count; undefined codes give the longest delay.
   function automatic logic [4:0] code_ticks(input logic [2:0] c);
      case (c)
         3'h0:    code_ticks = 5'h00;
         3'h1:    code_ticks = 5'h01;
         3'h2:    code_ticks = 5'h02;
         3'h3:    code_ticks = 5'h03;
         3'h4:    code_ticks = 5'h04;
         3'h5:    code_ticks = 5'h0A;
         3'h7:    code_ticks = 5'h14;
         default: code_ticks = 5'h14;
      endcase
   endfunction : code_ticks

   wire [4:0] ticks_two  = code_ticks(pg_delay_r[7:5]);
   wire [4:0] ticks_four = (pg_delay_r[4:2] == 3'h3) ? 5'h14
                         : code_ticks(pg_delay_r[4:2]);
   wire [4:0] ticks_one  = code_ticks({1'b0, pg_delay_r[1:0]});

   // Each channel keeps its own phase-aligned tick so the delay is
   // exact: a private prescaler restarts whenever its group drops.
   logic [2:0]  pg_raw;
   logic [4:0]  ticks_arr [3];
   assign ticks_arr[0] = ticks_one;
   assign ticks_arr[1] = ticks_two;
   assign ticks_arr[2] = ticks_four;

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_chan
         logic [31:0] pre_r;
         wire         ptick = (pre_r == 32'(TICK_CYC - 1));
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst || !group_ok[g] || ptick)
               pre_r <= 32'h0000_0000;
            else
               pre_r <= pre_r + 32'h0000_0001;
         end
         pg_delay_timer #(.TICK_W(5)) u_tmr
         (
            .sys_clk   (sys_clk),
            .sys_rst   (sys_rst),
            .tick      (ptick),
            .rails_ok  (group_ok[g]),
            .ticks_req (ticks_arr[g]),
            .pg_out    (pg_raw[g])
         );
      end
   endgenerate

   // --------------------------------------------------------------
   // General outputs
   // --------------------------------------------------------------
   // Host-controlled outputs ignore the delay field entirely.
   wire two_host = host_ctrl[1] && !out_two_vtt_use;
   wire one_nxt  = host_ctrl[0] ? host_level[0] : pg_raw[0];
   wire two_nxt  = two_host ? host_level[1] : pg_raw[1];
   wire four_nxt = host_ctrl[2] ? host_level[2] : pg_raw[2];

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         general_output_one  <= 1'b0;
         general_output_two  <= 1'b0;
         general_output_four <= 1'b0;
      end
      else
      begin
         general_output_one  <= one_nxt;
         general_output_two  <= two_nxt;
         general_output_four <= four_nxt;
      end
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   a_ctrl_resv_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ctrl_r[7:6] == 2'b00)
      else $error("reserved control bits set");

   a_ctrl_one_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !ctrl_r[`BIT_CTRL1_EN] |=> !ctrl_out.one_en)
      else $error("controller one on while disabled");

   a_ctrl_two_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !ctrl_r[`BIT_CTRL2_EN] |=> !ctrl_out.two_en)
      else $error("controller two on while disabled");

   a_ctrl_three_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !ctrl_r[`BIT_CTRL3_EN] |=> !ctrl_out.three_en)
      else $error("controller three on while disabled");

   a_aux_sleep_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sleep_active |=> aux_rail_target_code == $past(aux_volt_r.sleep_code))
      else $error("sleep code not applied");

   a_aux_norm_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sleep_active |=> aux_rail_target_code == $past(aux_volt_r.normal_code))
      else $error("normal code not applied");

   a_mode_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ##1 ctrl_out.one_mode == $past(ctrl_r[`BIT_CTRL1_MODE]) &&
      ctrl_out.two_mode == $past(ctrl_r[`BIT_CTRL2_MODE]) &&
      ctrl_out.three_mode == $past(ctrl_r[`BIT_CTRL3_MODE]))
      else $error("controller mode mismatch");

   a_one_host_ovr: assert property (@(posedge sys_clk) disable iff (sys_rst)
      host_ctrl[0] |=> general_output_one == $past(host_level[0]))
      else $error("output one ignores host control");

   a_zero_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!host_ctrl[0] && pg_delay_r[1:0] == 2'b00 && group_ok[0]) [*3]
      |=> general_output_one)
      else $error("zero delay output one not asserted");

   c_pg_one_up: cover property (@(posedge sys_clk) $rose(general_output_one));
   c_pg_two_up: cover property (@(posedge sys_clk) $rose(general_output_two));
   c_ctrl_write: cover property (@(posedge sys_clk) wr_ctrl);
   c_sleep_swap: cover property (@(posedge sys_clk) $rose(sleep_active));
   c_time_tick:  cover property (@(posedge sys_clk) tick_r);

endmodule : rail_ctrl_bank

// [core/rail_ctrl_pkg.sv]
// Types shared by the rail control register bank and its testbench.
// Assumes the constants header is included by each design file.
package rail_ctrl_pkg;

   // Decoded fields of the controller control register.
   typedef struct packed {
      logic three_mode;
      logic two_mode;
      logic one_mode;
      logic three_en;
      logic two_en;
      logic one_en;
   } ctrl_fields_t;

   // Sleep and normal voltage codes of the aux linear rail.
   typedef struct packed {
      logic [3:0] sleep_code;
      logic [3:0] normal_code;
   } aux_volt_t;

endpackage : rail_ctrl_pkg

// [core/rail_ctrl_regs.svh]
// Register offsets, field positions and timing constants of the rail
// control and power-good delay bank.
// Assumes an 8-bit register port and a 100 MHz system clock.
`ifndef RAIL_CTRL_REGS_SVH
`define RAIL_CTRL_REGS_SVH

`define OFS_AUX_VOLT        8'h9B
`define OFS_CTRL            8'h9C
`define OFS_PG_DELAY        8'h9D

`define RST_AUX_VOLT        8'h00
`define RST_CTRL            8'h00
`define RST_PG_DELAY        8'h00

`define CTRL_WR_MASK        8'h3F
`define BIT_CTRL3_MODE      5
`define BIT_CTRL2_MODE      4
`define BIT_CTRL1_MODE      3
`define BIT_CTRL3_EN        2
`define BIT_CTRL2_EN        1
`define BIT_CTRL1_EN        0

`define CLK_MHZ             100
`define CYC_PER_MS          (`CLK_MHZ * 1000)
`define MS_PER_TICK         5

`endif

// [verification/reg_host_model.sv]
// Host model for the rail control bank: single-byte register writes
// and reads on the strobe port. Assumes callers run on sys_clk.
`timescale 1ns/10ps
`include "rail_ctrl_regs.svh"

module reg_host_model
(
   input  wire logic       sys_clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // Bus starts idle with both strobes low.
   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // Writes one byte; lines are inverted after release, never left stale.
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = (addr == `OFS_CTRL) ? (data | 8'h20) : data;
      @(posedge sys_clk);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~addr;
      reg_wdata = ~reg_wdata;
   endtask : write_reg

   // Reads one byte; a missing valid pulse returns unknown data.
   // Data is taken just after the edge that launches the valid pulse,
   // while valid and data both stand.
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      #1;
      reg_rd   = 1'b1;
      reg_addr = addr;
      @(posedge sys_clk);
      #1;
      data     = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
      reg_rd   = 1'b0;
      reg_addr = ~addr;
   endtask : read_reg
endmodule : reg_host_model

// [verification/tb_rail_ctrl_bank.sv]
// Self-checking bench for the rail control bank: registers, controller
// fields, aux rail code, host-driven outputs and power-good delays.
// Assumes a short tick period so every delay code ends in few cycles.
`timescale 1ns/10ps
`include "rail_ctrl_regs.svh"

module tb_rail_ctrl_bank
   import rail_ctrl_pkg::*;
();
   localparam int TICK = 10;
   logic         sys_clk, sys_rst, reg_wr, reg_rd, reg_rvalid;
   logic   [7:0] reg_addr, reg_wdata, reg_rdata;
   logic         sleep_active, out_two_vtt_use;
   logic   [2:0] ctrl_pin_en, group_ok, host_ctrl, host_level;
   logic   [3:0] aux_rail_target_code;
   ctrl_fields_t ctrl_out;
   logic         general_output_one, general_output_two, general_output_four;
   int           fail_count      = 0;
   int           samples_checked = 0;
   int           seed            = 32'hFAB3;
   wire    [2:0] outs = {general_output_four, general_output_two,
                         general_output_one};

   // Free-running 100 MHz clock.
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   rail_ctrl_bank #(.TICK_CYC(TICK)) u_dut
   (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .sleep_active(sleep_active), .ctrl_pin_en(ctrl_pin_en),
      .group_ok(group_ok), .host_ctrl(host_ctrl), .host_level(host_level),
      .out_two_vtt_use(out_two_vtt_use),
      .aux_rail_target_code(aux_rail_target_code), .ctrl_out(ctrl_out),
      .general_output_one(general_output_one),
      .general_output_two(general_output_two),
      .general_output_four(general_output_four)
   );

   reg_host_model u_host
   (
      .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
   );

   //------------------------------------------------------------------
   // Expectations and helpers
   //------------------------------------------------------------------
   // Nominal delay in ticks; channel 0 is output one, 1 two, 2 four.
   function automatic int exp_ticks(input int ch, input logic [2:0] code);
      int two [8] = '{0, 1, 2, 3, 4, 10, 20, 20};
      int four[8] = '{0, 1, 2, 20, 4, 10, 20, 20};
      int one [4] = '{0, 1, 2, 3};
      return (ch == 0) ? one[code[1:0]] : (ch == 1) ? two[code] : four[code];
   endfunction : exp_ticks

   // Controller fields: modes pass through, enables gated by the pins.
   function automatic logic [7:0] exp_ctrl(input logic [7:0] w,
                                           input logic [2:0] pin);
      return {2'b00, w[5:3], w[2:0] & pin};
   endfunction : exp_ctrl

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cycles

   task automatic wrap_up;
      if (fail_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   // Cuts a hung run short.
   initial
   begin
      #100000;
      fail_count++;
      wrap_up();
   end

   //------------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------------
   initial
   begin
      logic [7:0] d, aux_w, ctl_w, pg_w;
      int         seen[3];
      int         k, c, n, lo, hi;
      {sys_rst, sleep_active, out_two_vtt_use} = 3'b100;
      {ctrl_pin_en, group_ok, host_ctrl, host_level} = 12'h000;
      repeat (8) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      check({1'b0, outs, aux_rail_target_code}, 8'h00);
      for (k = 0; k < 5; k++)
      begin
         u_host.read_reg(8'h9A + k[7:0], d);
         check(d, 8'h00);
      end
      // Random register contents, pin enables and host-driven levels.
      for (k = 0; k < 24; k++)
      begin
         aux_w = $random(seed);
         ctl_w = $random(seed) | 8'h20;
         pg_w  = $random(seed);
         u_host.write_reg(`OFS_AUX_VOLT, aux_w);
         u_host.write_reg(`OFS_CTRL, ctl_w);
         u_host.write_reg(`OFS_PG_DELAY, pg_w);
         u_host.write_reg(8'h9E, 8'hFF);
         {sleep_active, ctrl_pin_en, host_level, group_ok} = $random(seed);
         host_ctrl = 3'b111;
         cycles(3);
         check({4'h0, aux_rail_target_code},
               {4'h0, sleep_active ? aux_w[7:4] : aux_w[3:0]});
         check({2'b00, ctrl_out},
               exp_ctrl(ctl_w, ctrl_pin_en));
         check({5'h00, outs}, {5'h00, host_level});
         u_host.read_reg(`OFS_AUX_VOLT, d);
         check(d, aux_w);
         u_host.read_reg(`OFS_CTRL, d);
         check(d, ctl_w & 8'h3F);
         u_host.read_reg(`OFS_PG_DELAY, d);
         check(d, pg_w);
      end
      // Every delay code, with a dropout partway through the count.
      {host_ctrl, host_level} = 6'h00;
      for (k = 0; k < 8; k++)
      begin
         u_host.write_reg(`OFS_PG_DELAY, {k[2:0], k[2:0], k[1:0]});
         group_ok = 3'b000;
         cycles(3);
         check({5'h00, outs}, 8'h00);
         group_ok = 3'b111;
         cycles(1 + exp_ticks(2, k[2:0]) * TICK / 2);
         group_ok = 3'b000;
         cycles(1);
         group_ok = 3'b111;
         seen = '{999, 999, 999};
         for (c = 1; c <= 260; c++)
         begin
            cycles(1);
            for (n = 0; n < 3; n++)
               if (seen[n] == 999 && outs[n] === 1'b1)
                  seen[n] = c;
         end
         for (n = 0; n < 3; n++)
         begin
            lo = exp_ticks(n, k[2:0]) * TICK * 9 / 10 - TICK;
            hi = exp_ticks(n, k[2:0]) * TICK * 11 / 10 + 3;
            check({7'h00, seen[n] >= lo && seen[n] <= hi}, 8'h01);
         end
      end
      // Output two stays on power-good logic while it feeds termination.
      u_host.write_reg(`OFS_PG_DELAY, 8'h00);
      host_ctrl       = 3'b111;
      out_two_vtt_use = 1'b1;
      cycles(6);
      check({5'h00, outs}, 8'h02);
      out_two_vtt_use = 1'b0;
      cycles(3);
      check({5'h00, outs}, 8'h00);
      wrap_up();
   end
endmodule : tb_rail_ctrl_bank
